// [dv/fbc_flash_model.sv]
// Behavioural flash array facing the sequencer's read and operation ports
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model
   import fbc_pkg::*;
#(
   parameter int OP_CYCLES = 8 // Cycles an auto erase or program takes
) (
   input wire logic clock,
   input wire logic rst,
   input wire fbc_mem_req_type memReq,
   output logic [7:0] memData,
   input wire logic opStart,
   output logic opDone,
   output logic opFail,
   input wire logic badEn,
   input wire logic [15:0] badAddr,
   input wire logic failMode
);
   int opCount; // Cycles left in a running operation

   // Read data answers one cycle after rd
   // Idle cycles toggle so stale data never passes for an answer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         memData <= 8'h5A;
      end else if (memReq.rd) begin
         // One byte that is not blank when badEn is set
         if (badEn && memReq.addr == badAddr) begin
            memData <= 8'hFE;
         end else begin
            memData <= BLANK_BYTE;
         end
      end else begin
         memData <= ~memData;
      end
   end

   // Erase and program end after a fixed time, failing on request
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         opCount <= 0;
         opDone <= 1'b0;
         opFail <= 1'b0;
      end else begin
         opDone <= 1'b0;
         opFail <= 1'b0;
         if (opStart) begin
            opCount <= OP_CYCLES;
         end else if (opCount == 1) begin
            opCount <= 0;
            opDone <= 1'b1;
            opFail <= failMode;
         end else if (opCount > 1) begin
            opCount <= opCount - 1;
         end
      end
   end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fbc_pkg::*;
   localparam logic [31:0] RDY = 32'h0000_0001 << ST_READY;
   localparam logic [31:0] SUS = 32'h0000_0001 << ST_SUSPEND;
   localparam logic [31:0] EE = 32'h0000_0001 << ST_ERASE_ERR;
   localparam logic [31:0] PE = 32'h0000_0001 << ST_PROG_ERR;
   logic clock, rst, avsRead, avsWrite, avsWaitRequest, opStart, opDone;
   logic opFail, eraseSuspend, idCheck, readArrayMode, irq, badEn, failMode;
   logic [3:0] avsAddress;
   logic [31:0] avsWriteData, avsReadData, v;
   logic [7:0] memData;
   logic [15:0] badAddr;
   logic [55:0] idReceived, idStored;
   fbc_mem_req_type memReq;
   int n_mismatch, n_tests;

   fbc_sequencer #(.BLOCK_BITS(3), .ID_BITS(56)) u_dut (.clock(clock),
      .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .memReq(memReq), .memData(memData), .opStart(opStart),
      .opDone(opDone), .opFail(opFail), .eraseSuspend(eraseSuspend),
      .idReceived(idReceived), .idStored(idStored), .idCheck(idCheck),
      .readArrayMode(readArrayMode), .irq(irq));
   fbc_flash_model #(.OP_CYCLES(8)) u_flash (.clock(clock), .rst(rst),
      .memReq(memReq), .memData(memData), .opStart(opStart),
      .opDone(opDone), .opFail(opFail), .badEn(badEn),
      .badAddr(badAddr), .failMode(failMode));

   // Clock at 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Verdict and end of run
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Compare a 32-bit result
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   // Avalon cycle: hold until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= w;
      avsRead <= ~w;
      do begin
         @(posedge clock);
         n++;
      end while (avsWaitRequest !== 1'b0 && n < 50);
      q = avsReadData;
      if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // Commands are plain data writes; no trap vector fetch is modelled
   task automatic cmd(input logic [7:0] c);
      wr(OFS_COMMAND, {24'h00_0000, c});
   endtask

   // Two-cycle operation on block 2, busy seen, then poll ready
   task automatic op(input logic [7:0] c1, input logic [7:0] c2);
      int n;
      wr(OFS_ADDR, 32'h0000_0010);
      cmd(c1);
      cmd(c2);
      bus(1'b0, OFS_STATUS, 32'h0, v);
      chk("busy", 32'h0, v & RDY);
      n = 0;
      while (v[ST_READY] !== 1'b1 && n < 100) begin
         bus(1'b0, OFS_STATUS, 32'h0, v);
         n++;
      end
   endtask

   task automatic st(input string what, input logic [31:0] e);
      bus(1'b0, OFS_STATUS, 32'h0, v);
      chk(what, e, v & (RDY | EE | PE));
   endtask

   // Watchdog far beyond the expected run length
   initial begin
      #(100 * 30000);
      n_mismatch++;
      close_out();
   end

   initial begin
      {avsRead, avsWrite, eraseSuspend, idCheck, badEn, failMode} = '0;
      avsAddress = 4'h0;
      avsWriteData = 32'h0;
      badAddr = 16'h0015;
      idStored = 56'h12_3456_789A_BCDE;
      idReceived = 56'h12_3456_789A_BCDE;
      n_mismatch = 0;
      n_tests = 0;
      rst = 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      bus(1'b0, OFS_STATUS, 32'h0, v);
      chk("status reset", {24'h00_0000, STATUS_RESET}, v);
      chk("read mode reset", 32'h1, {31'h0, readArrayMode});
      // Mask resets to zero; enable both events before testing irq
      wr(OFS_IRQ_MASK, 32'h0000_0003);
      op(CMD_BLANK_CHECK, CMD_CONFIRM);
      st("blank pass", RDY);
      chk("irq done", 32'h1, {31'h0, irq});
      wr(OFS_IRQ_STAT, 32'h0000_0003);
      @(posedge clock);
      chk("irq cleared", 32'h0, {31'h0, irq});
      badEn <= 1'b1;
      op(CMD_BLANK_CHECK, CMD_CONFIRM);
      st("blank error", RDY | EE);
      bus(1'b0, OFS_IRQ_STAT, 32'h0, v);
      chk("error event", 32'h2, v & 32'h2);
      chk("irq error", 32'h1, {31'h0, irq});
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      @(posedge clock);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_IRQ_STAT, 32'h0000_0003);
      wr(OFS_IRQ_MASK, 32'h0000_0003);
      @(posedge clock);
      chk("irq after clear", 32'h0, {31'h0, irq});
      badEn <= 1'b0;
      op(CMD_BLANK_CHECK, CMD_CONFIRM);
      st("error sticky", RDY | EE);
      cmd(CMD_CLEAR_STATUS);
      st("clear status", RDY);
      cmd(8'h33);
      st("unknown code", RDY | EE | PE);
      cmd(CMD_CLEAR_STATUS);
      cmd(CMD_BLOCK_ERASE);
      cmd(8'h12);
      st("erase bad confirm", RDY | EE | PE);
      cmd(CMD_CLEAR_STATUS);
      failMode <= 1'b1;
      op(CMD_BLOCK_ERASE, CMD_CONFIRM);
      st("erase fail", RDY | EE);
      cmd(CMD_CLEAR_STATUS);
      op(CMD_PROGRAM, 8'h5A);
      st("program fail", RDY | PE);
      cmd(CMD_CLEAR_STATUS);
      failMode <= 1'b0;
      op(CMD_BLOCK_ERASE, CMD_CONFIRM);
      st("erase pass", RDY);
      cmd(CMD_BLANK_CHECK);
      cmd(CMD_READ_ARRAY);
      st("abort blank", RDY);
      chk("read mode", 32'h1, {31'h0, readArrayMode});
      cmd(CMD_BLOCK_ERASE);
      cmd(CMD_READ_ARRAY);
      st("abort erase", RDY);
      idCheck <= 1'b1;
      @(posedge clock);
      idCheck <= 1'b0;
      bus(1'b0, OFS_STATUS, 32'h0, v);
      chk("id match", 32'h1, v & 32'h1);
      idReceived <= 56'h12_3456_789A_BCDF;
      idCheck <= 1'b1;
      @(posedge clock);
      idCheck <= 1'b0;
      bus(1'b0, OFS_STATUS, 32'h0, v);
      chk("id mismatch", 32'h0, v & 32'h1);
      // No blank check is issued while suspended
      eraseSuspend <= 1'b1;
      repeat (4) @(posedge clock);
      bus(1'b0, OFS_STATUS, 32'h0, v);
      chk("suspend flag", SUS, v & SUS);
      eraseSuspend <= 1'b0;
      bus(1'b0, 4'h2, 32'h0, v);
      chk("unmapped read", 32'h0, v);
      close_out();
   end
endmodule
`default_nettype wire

// [hdl/fbc_sequencer.sv]
// Flash command sequencer with blank check and full status reporting
`timescale 1ns/1ps
`default_nettype none
module fbc_sequencer
   import fbc_pkg::*;
#(
   parameter int BLOCK_BITS = 10, // Bytes per block as log2
   parameter int ID_BITS = 56 // Width of the serial ID code
) (
   input wire logic clock,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // Flash array read port (data valid one cycle after request)
   output fbc_mem_req_type memReq,
   input wire logic [7:0] memData,
   // Completion from the array for erase and program
   output logic opStart,
   input wire logic opDone,
   input wire logic opFail,
   input wire logic eraseSuspend,
   // ID check
   input wire logic [ID_BITS-1:0] idReceived,
   input wire logic [ID_BITS-1:0] idStored,
   input wire logic idCheck,
   output logic readArrayMode,
   output logic irq
);
   // Offset mask within a block (bytes per block minus one)
   localparam logic [15:0] BLOCK_MASK = 16'((1 << BLOCK_BITS) - 1);

   typedef enum logic [2:0] {
      S_IDLE,
      S_SECOND,
      S_BLANK,
      S_BLANK_LAST,
      S_WAIT_OP
   } fbc_state_type;

   fbc_state_type state_r; // Sequencer state
   logic [7:0] firstCmd_r; // Code from first bus cycle
   fbc_op_type op_r; // Running operation
   logic [15:0] scanAddr_r; // Blank scan pointer
   logic ready_r; // Ready flag
   logic eraseErr_r; // Erase or blank error flag
   logic progErr_r; // Program error flag
   logic idOk_r; // ID match result
   logic susp1_r, susp2_r; // Suspend synchroniser
   logic [1:0] irqStat_r; // Sticky events
   logic [1:0] irqMask_r; // Event mask
   logic [15:0] cmdAddr_r; // Address for command cycles
   logic busAck_r; // One wait state then answer
   logic waitReq_r; // Registered waitrequest, inverse of busAck_r
   logic [31:0] rdData_r; // Registered read data
   logic readArr_r; // Read array mode
   logic opStart_r; // Start pulse to array
   logic memRd_r; // Array read strobe
   logic memValid_r; // memData answers the strobe of the last cycle

   // Write accepted on the cycle waitrequest is low
   logic wrCmd, wrAddr, wrIrqStat, wrIrqMask;
   logic [7:0] cmd;
   logic setErase, setProg, setBoth, clrErr, evDone, blankBad;
   assign cmd = avsWriteData[7:0];
   assign wrCmd = avsWrite && busAck_r && avsAddress == OFS_COMMAND;
   assign wrAddr = avsWrite && busAck_r && avsAddress == OFS_ADDR;
   assign wrIrqStat = avsWrite && busAck_r && avsAddress == OFS_IRQ_STAT;
   assign wrIrqMask = avsWrite && busAck_r && avsAddress == OFS_IRQ_MASK;

   // Bus handshake: every access takes one wait state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busAck_r <= 1'b0;
         waitReq_r <= 1'b1;
      end else begin
         busAck_r <= (avsRead || avsWrite) && !busAck_r;
         waitReq_r <= !((avsRead || avsWrite) && !busAck_r);
      end
   end

   // Read data mux; unmapped offsets read zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdData_r <= 32'h0000_0000;
      end else if (avsRead && !busAck_r) begin
         case (avsAddress)
            OFS_STATUS: rdData_r <= {24'h0000_00, ready_r, susp2_r,
               eraseErr_r, progErr_r, 3'h0, idOk_r};
            OFS_ADDR: rdData_r <= {16'h0000, cmdAddr_r};
            OFS_IRQ_STAT: rdData_r <= {30'h0000_0000, irqStat_r};
            default: rdData_r <= 32'h0000_0000;
         endcase
      end
   end

   // Suspend flag comes from the array domain edge; two stages
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         susp1_r <= 1'b0;
         susp2_r <= 1'b0;
      end else begin
         susp1_r <= eraseSuspend;
         susp2_r <= susp1_r;
      end
   end

   // Address register for the second command cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmdAddr_r <= 16'h0000;
      end else if (wrAddr) begin
         cmdAddr_r <= avsWriteData[15:0];
      end
   end

   // Command sequencer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= S_IDLE;
         firstCmd_r <= 8'h00;
         op_r <= OP_NONE;
         scanAddr_r <= 16'h0000;
         readArr_r <= 1'b1;
         opStart_r <= 1'b0;
         memRd_r <= 1'b0;
         memValid_r <= 1'b0;
      end else begin
         opStart_r <= 1'b0;
         // Array answers a cycle late; the first scan cycle sees stale data
         memValid_r <= memRd_r;
         case (state_r)
            S_IDLE: begin
               if (wrCmd) begin
                  if (cmd == CMD_READ_ARRAY) begin
                     readArr_r <= 1'b1;
                  end else if (cmd == CMD_PROGRAM ||
                     cmd == CMD_BLOCK_ERASE ||
                     cmd == CMD_BLANK_CHECK) begin
                     firstCmd_r <= cmd;
                     readArr_r <= 1'b0;
                     state_r <= S_SECOND;
                  end
               end
            end
            S_SECOND: begin
               if (wrCmd) begin
                  state_r <= S_IDLE;
                  if (firstCmd_r != CMD_PROGRAM && cmd == CMD_READ_ARRAY)
                  begin
                     readArr_r <= 1'b1;
                  end else if (firstCmd_r == CMD_PROGRAM) begin
                     op_r <= OP_PROG;
                     opStart_r <= 1'b1;
                     state_r <= S_WAIT_OP;
                  end else if (cmd == CMD_CONFIRM &&
                     firstCmd_r == CMD_BLOCK_ERASE) begin
                     op_r <= OP_ERASE;
                     opStart_r <= 1'b1;
                     state_r <= S_WAIT_OP;
                  end else if (cmd == CMD_CONFIRM) begin
                     // Scan starts at the block base of the address
                     op_r <= OP_BLANK;
                     scanAddr_r <= cmdAddr_r & ~BLOCK_MASK;
                     memRd_r <= 1'b1;
                     state_r <= S_BLANK;
                  end
               end
            end
            S_BLANK: begin
               // Error found ends the scan early
               if (blankBad) begin
                  memRd_r <= 1'b0;
                  state_r <= S_IDLE;
                  op_r <= OP_NONE;
               end else if ((scanAddr_r & BLOCK_MASK) == BLOCK_MASK) begin
                  memRd_r <= 1'b0;
                  state_r <= S_BLANK_LAST;
               end else begin
                  scanAddr_r <= scanAddr_r + 16'h0001;
               end
            end
            S_BLANK_LAST: begin
               state_r <= S_IDLE;
               op_r <= OP_NONE;
            end
            S_WAIT_OP: begin
               if (opDone) begin
                  state_r <= S_IDLE;
                  op_r <= OP_NONE;
                  readArr_r <= 1'b1;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Error causes; array data counts only once it answers a strobe
   assign blankBad = (state_r == S_BLANK || state_r == S_BLANK_LAST)
      && memValid_r && memData != BLANK_BYTE;
   assign setErase = blankBad
      || (state_r == S_WAIT_OP && opDone && opFail && op_r == OP_ERASE);
   assign setProg = state_r == S_WAIT_OP && opDone && opFail
      && op_r == OP_PROG;
   assign setBoth = wrCmd && ((state_r == S_IDLE && cmd != CMD_READ_ARRAY
      && cmd != CMD_PROGRAM && cmd != CMD_BLOCK_ERASE
      && cmd != CMD_BLANK_CHECK && cmd != CMD_CLEAR_STATUS)
      || (state_r == S_SECOND && firstCmd_r != CMD_PROGRAM
      && cmd != CMD_CONFIRM && cmd != CMD_READ_ARRAY));
   assign clrErr = wrCmd && state_r == S_IDLE && cmd == CMD_CLEAR_STATUS;
   assign evDone = (state_r == S_BLANK_LAST)
      || (state_r == S_BLANK && blankBad)
      || (state_r == S_WAIT_OP && opDone);

   // Error flags: set wins over clear, stay until cleared
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         eraseErr_r <= 1'b0;
         progErr_r <= 1'b0;
      end else begin
         eraseErr_r <= (eraseErr_r && !clrErr) || setErase
            || setBoth;
         progErr_r <= (progErr_r && !clrErr) || setProg
            || setBoth;
      end
   end

   // Ready flag low while any operation runs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ready_r <= 1'b1;
      end else begin
         ready_r <= !(state_r == S_BLANK || state_r == S_WAIT_OP
            || (state_r == S_SECOND && wrCmd && cmd == CMD_CONFIRM
            && firstCmd_r != CMD_PROGRAM)
            || (state_r == S_SECOND && wrCmd && firstCmd_r == CMD_PROGRAM))
            || (state_r == S_WAIT_OP && opDone)
            || (state_r == S_BLANK && blankBad);
      end
   end

   // ID comparison for serial programming
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         idOk_r <= 1'b0;
      end else if (idCheck) begin
         idOk_r <= idReceived == idStored;
      end
   end

   // Interrupt status and mask; write one clears, set wins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqStat_r <= 2'h0;
         irqMask_r <= MASK_RESET;
      end else begin
         irqStat_r[EV_DONE] <= evDone
            || (irqStat_r[EV_DONE] && !(wrIrqStat && avsWriteData[EV_DONE]));
         irqStat_r[EV_ERROR] <= setErase || setProg || setBoth
            || (irqStat_r[EV_ERROR]
            && !(wrIrqStat && avsWriteData[EV_ERROR]));
         if (wrIrqMask) begin
            irqMask_r <= avsWriteData[1:0];
         end
      end
   end

   // Interrupt output registered
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_r & irqMask_r);
      end
   end

   assign avsWaitRequest = waitReq_r;
   assign avsReadData = rdData_r;
   assign memReq = '{rd: memRd_r, addr: scanAddr_r};
   assign opStart = opStart_r;
   assign readArrayMode = readArr_r;

   // Checks
   chk_clear_errs: assert property (@(posedge clock) disable iff (rst)
      clrErr && !setErase && !setProg && !setBoth |=> !eraseErr_r
      && !progErr_r) else $error("clear failed");
   chk_seq_err: assert property (@(posedge clock) disable iff (rst)
      setBoth |=> eraseErr_r && progErr_r) else $error("seq err");
   chk_erase_err: assert property (@(posedge clock) disable iff (rst)
      setErase |=> eraseErr_r) else $error("erase err");
   chk_prog_err: assert property (@(posedge clock) disable iff (rst)
      setProg |=> progErr_r) else $error("prog err");
   chk_err_sticky: assert property (@(posedge clock) disable iff (rst)
      eraseErr_r && !clrErr |=> eraseErr_r) else $error("lost");
   chk_busy_low: assert property (@(posedge clock) disable iff (rst)
      state_r == S_BLANK && !blankBad |=> !ready_r) else $error("rdy");
   chk_blank_start: assert property (@(posedge clock) disable iff (rst)
      state_r == S_SECOND && wrCmd && cmd == CMD_CONFIRM
      && firstCmd_r == CMD_BLANK_CHECK |=> state_r == S_BLANK)
      else $error("blank start");
   chk_read_escape: assert property (@(posedge clock) disable iff (rst)
      state_r == S_SECOND && wrCmd && cmd == CMD_READ_ARRAY
      && firstCmd_r != CMD_PROGRAM |=> readArr_r && state_r == S_IDLE)
      else $error("escape");
   cov_blank: cover property (@(posedge clock) state_r == S_BLANK_LAST);
   cov_bad: cover property (@(posedge clock) blankBad);
   cov_seq: cover property (@(posedge clock) setBoth);
endmodule
`default_nettype wire

// [include/fbc_pkg.sv]
// Package of constants and types for the flash command sequencer
package fbc_pkg;
   // Register byte offsets
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_COMMAND = 4'h4;
   localparam logic [3:0] OFS_ADDR = 4'h8;
   localparam logic [3:0] OFS_IRQ_STAT = 4'hC;
   // Mask shares the status offset: status is read-only, writes land here
   localparam logic [3:0] OFS_IRQ_MASK = 4'h0;
   // Command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] CMD_BLANK_CHECK = 8'h25;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   // Status bit positions
   localparam int ST_READY = 7;
   localparam int ST_SUSPEND = 6;
   localparam int ST_ERASE_ERR = 5;
   localparam int ST_PROG_ERR = 4;
   localparam int ST_ID_OK = 0;
   // Interrupt event bit positions
   localparam int EV_DONE = 0;
   localparam int EV_ERROR = 1;
   // Reset values
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // Cycles taken per byte by an auto operation
   localparam logic [3:0] OP_STEP_CYCLES = 4'h1;

   // Memory request toward the flash array
   typedef struct packed {
      logic rd;
      logic [15:0] addr;
   } fbc_mem_req_type;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_BLANK,
      OP_ERASE,
      OP_PROG
   } fbc_op_type;
endpackage
